// >>> src/epiv_top.sv
// Functional notes
// - Every reset cause vectors to address zero, vector number one.
// - External irq at 1, pin-change low 2, high 3, watchdog 4.
// - 16-bit timer capture, compare A, compare B, overflow at 5..8.
// - 8-bit timer at 9..11; comparator, converter, eeprom, serial at 12..16.
// - Pin activity raises interrupts even when the pin drives as output.
// - Any enabled change on inputs 0..7 raises low group request.
// - Any enabled change on inputs 8..11 raises high group request.
// - Only mask-enabled pins contribute to each group request.
// - Pin changes are seen without a clock, waking from any sleep.
// - External pin senses falling edge, rising edge or low level.
// - Level mode requests continuously while the pin stays low.
// - Edge detection works only while the I/O clock runs.
// - Low level is detected without a clock for wake-up.
// - Level released before start-up ends wakes but raises no interrupt.
// - Then no branch occurs; execution resumes after the sleep instruction.
// - Sense 00 low, 01 any change, 10 falling, 11 rising.
// - Ext flag sets on edge, clears on entry or write one, zero in level.
// - Group flags set on change, clear on entry or write one.
// - Dispatch needs its enable bit and global enable both set.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
module epiv_top
  import epiv_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic io_clk_en,
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  input wire logic startup_done,
  input wire logic ext_irq_pin,
  input wire logic [PIN_W-1:0] pin_change_inputs,
  input wire epiv_src_type other_src,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output epiv_req_type irq_req,
  output logic wake_req,
  output logic reset_vector_valid,
  output logic [4:0] reset_vector
);

  // ==========================================================================
  // Synchronisers
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic [PIN_W-1:0] pch_meta;
  logic [PIN_W-1:0] pch_sync;
  logic [PIN_W-1:0] pch_prev;

  // Idle high, so no false edge follows reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
    end
    else
    begin
      ext_meta <= ext_irq_pin;
      ext_sync <= ext_meta;
    end
  end

  // Pin levels are read whatever the pin direction
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pch_meta <= '0;
      pch_sync <= '0;
    end
    else
    begin
      pch_meta <= pin_change_inputs;
      pch_sync <= pch_meta;
    end
  end

  // Previous samples only advance with the I/O clock
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_prev <= 1'b1;
    end
    else if (io_clk_en)
    begin
      ext_prev <= ext_sync;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pch_prev <= '0;
    end
    else if (io_clk_en)
    begin
      pch_prev <= pch_sync;
    end
  end

  // ==========================================================================
  // Registers
  logic [1:0] core_control_reg;
  logic [2:0] general_irq_mask;
  logic [LOW_GROUP_W-1:0] pin_change_mask_low;
  logic [HIGH_GROUP_W-1:0] pin_change_mask_high;
  logic ext_irq_flag;
  logic pin_change_flag_low;
  logic pin_change_flag_high;

  wire epiv_sense_type sense = epiv_sense_type'(core_control_reg);
  wire sense_sel_hi = core_control_reg[SENSE_HI_BIT];
  wire sense_sel_lo = core_control_reg[SENSE_LO_BIT];
  wire level_mode = (sense == SENSE_LOW_LEVEL);
  wire ext_en = general_irq_mask[2];
  wire pch_high_en = general_irq_mask[1];
  wire pch_low_en = general_irq_mask[0];

  // ==========================================================================
  // Event detection
  wire ext_rise = ext_sync & ~ext_prev;
  wire ext_fall = ~ext_sync & ext_prev;
  // Edges need the I/O clock running
  wire ext_edge_hit = io_clk_en & ((sense == SENSE_ANY_CHANGE) & (ext_rise | ext_fall)
    | (sense == SENSE_FALLING) & ext_fall
    | (sense == SENSE_RISING) & ext_rise);
  wire ext_level_req = level_mode & ~ext_sync & startup_done;

  wire [PIN_W-1:0] pch_toggle;
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1)
    begin : g_toggle
      assign pch_toggle[gi] = io_clk_en & (pch_sync[gi] ^ pch_prev[gi]);
    end
  endgenerate
  wire pch_low_hit = |(pch_toggle[LOW_GROUP_W-1:0] & pin_change_mask_low);
  wire pch_high_hit = |(pch_toggle[PIN_W-1:LOW_GROUP_W] & pin_change_mask_high);

  // Asynchronous wake: raw pins, no clock needed
  wire [PIN_W-1:0] wake_mask = {pin_change_mask_high, pin_change_mask_low};
  wire pch_wake = |((pin_change_inputs ^ pch_sync) & wake_mask);
  wire level_wake = level_mode & ext_en & ~ext_irq_pin;

  // ==========================================================================
  // AHB-Lite slave
  logic dp_write;
  logic [7:0] dp_addr;
  wire addr_phase = hsel & hready & htrans[1];
  wire wr_ctrl = dp_write & (dp_addr == ADDR_CORE_CONTROL);
  wire wr_gmask = dp_write & (dp_addr == ADDR_GENERAL_MASK);
  wire wr_flags = dp_write & (dp_addr == ADDR_FLAGS);
  wire wr_mlow = dp_write & (dp_addr == ADDR_MASK_LOW);
  wire wr_mhigh = dp_write & (dp_addr == ADDR_MASK_HIGH);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dp_write <= 1'b0;
      dp_addr <= RESET_VALUE;
    end
    else
    begin
      dp_write <= addr_phase & hwrite;
      dp_addr <= addr_phase ? haddr[7:0] : dp_addr;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      core_control_reg <= '0;
    end
    else if (wr_ctrl)
    begin
      core_control_reg <= {hwdata[SENSE_HI_BIT], hwdata[SENSE_LO_BIT]};
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      general_irq_mask <= '0;
    end
    else if (wr_gmask)
    begin
      general_irq_mask <= {hwdata[EXT_BIT], hwdata[PCH_HIGH_BIT], hwdata[PCH_LOW_BIT]};
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_change_mask_low <= '0;
    end
    else if (wr_mlow)
    begin
      pin_change_mask_low <= hwdata[LOW_GROUP_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_change_mask_high <= '0;
    end
    else if (wr_mhigh)
    begin
      pin_change_mask_high <= hwdata[HIGH_GROUP_W-1:0];
    end
  end

  // ==========================================================================
  // Flags: hardware set beats software or acknowledge clear
  logic ack_ext;
  logic ack_low;
  logic ack_high;
  wire next_ext_irq_flag = level_mode ? 1'b0
    : ext_edge_hit | (ext_irq_flag & ~ack_ext & ~(wr_flags & hwdata[EXT_BIT]));
  wire next_flag_low = pch_low_hit
    | (pin_change_flag_low & ~ack_low & ~(wr_flags & hwdata[PCH_LOW_BIT]));
  wire next_flag_high = pch_high_hit
    | (pin_change_flag_high & ~ack_high & ~(wr_flags & hwdata[PCH_HIGH_BIT]));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_irq_flag <= 1'b0;
    end
    else
    begin
      ext_irq_flag <= next_ext_irq_flag;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_change_flag_low <= 1'b0;
    end
    else
    begin
      pin_change_flag_low <= next_flag_low;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_change_flag_high <= 1'b0;
    end
    else
    begin
      pin_change_flag_high <= next_flag_high;
    end
  end

  // ==========================================================================
  // Priority and vector selection
  wire gie = global_irq_enable;
  // Level request vanishes if released early, so no branch is taken
  wire [NUM_SRC-1:0] pending = {other_src,
    gie & pch_high_en & pin_change_flag_high,
    gie & pch_low_en & pin_change_flag_low,
    gie & ext_en & (ext_irq_flag | ext_level_req)};
  wire [NUM_SRC-1:0] other_pending = {pending[NUM_SRC-1:3] & {(NUM_SRC-3){gie}}, pending[2:0]};

  logic [4:0] next_vector;
  logic next_valid;
  always_comb
  begin
    next_vector = VEC_RESET;
    next_valid = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (other_pending[i])
      begin
        next_vector = VEC_EXT + 5'(i);
        next_valid = 1'b1;
      end
    end
  end

  // Acknowledge clears the flag of the vector being served
  assign ack_ext = irq_ack & irq_req.valid & (irq_req.vector == VEC_EXT);
  assign ack_low = irq_ack & irq_req.valid & (irq_req.vector == VEC_PCH_LOW);
  assign ack_high = irq_ack & irq_req.valid & (irq_req.vector == VEC_PCH_HIGH);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_req <= '0;
    end
    else
    begin
      irq_req.valid <= next_valid & ~irq_ack;
      irq_req.vector <= next_vector;
    end
  end

  // ==========================================================================
  // Outputs
  assign wake_req = pch_wake | level_wake;
  assign reset_vector_valid = 1'b1;
  assign reset_vector = VEC_RESET;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire [31:0] rd_status = {26'h0, irq_req.vector, ext_sync};
  wire [31:0] rd_flags = {25'h0, ext_irq_flag, pin_change_flag_high, pin_change_flag_low, 4'h0};
  wire [31:0] rd_gmask = {25'h0, general_irq_mask, 4'h0};
  wire [31:0] rd_ctrl = {30'h0, sense_sel_hi, sense_sel_lo};
  wire [31:0] rd_mux = (haddr[7:0] == ADDR_CORE_CONTROL) ? rd_ctrl
    : (haddr[7:0] == ADDR_GENERAL_MASK) ? rd_gmask
    : (haddr[7:0] == ADDR_FLAGS) ? rd_flags
    : (haddr[7:0] == ADDR_MASK_LOW) ? {24'h0, pin_change_mask_low}
    : (haddr[7:0] == ADDR_MASK_HIGH) ? {28'h0, pin_change_mask_high}
    : (haddr[7:0] == ADDR_STATUS) ? rd_status
    : 32'h0;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      hrdata <= 32'h0;
    else if (addr_phase & ~hwrite)
      hrdata <= rd_mux;
  end

endmodule

// >>> src/epiv_pkg.sv
package epiv_pkg;

  // ==========================================================================
  // Register map (word aligned, byte addresses)
  localparam logic [7:0] ADDR_CORE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_GENERAL_MASK = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_MASK_LOW = 8'h0C;
  localparam logic [7:0] ADDR_MASK_HIGH = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int SENSE_LO_BIT = 0;
  localparam int SENSE_HI_BIT = 1;
  localparam int EXT_BIT = 6;
  localparam int PCH_HIGH_BIT = 5;
  localparam int PCH_LOW_BIT = 4;
  localparam int LOW_GROUP_W = 8;
  localparam int HIGH_GROUP_W = 4;
  localparam int PIN_W = LOW_GROUP_W + HIGH_GROUP_W;
  localparam int NUM_SRC = 17;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ==========================================================================
  // Vector addresses
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_EXT = 5'h01;
  localparam logic [4:0] VEC_PCH_LOW = 5'h02;
  localparam logic [4:0] VEC_PCH_HIGH = 5'h03;
  localparam logic [4:0] VEC_WATCHDOG = 5'h04;
  localparam logic [4:0] VEC_T16_CAPTURE = 5'h05;
  localparam logic [4:0] VEC_T16_OVERFLOW = 5'h08;
  localparam logic [4:0] VEC_T8_COMPARE_A = 5'h09;
  localparam logic [4:0] VEC_COMPARATOR = 5'h0C;
  localparam logic [4:0] VEC_SERIAL_OVERFLOW = 5'h10;

  typedef enum logic [1:0]
  {
    SENSE_LOW_LEVEL = 2'h0,
    SENSE_ANY_CHANGE = 2'h1,
    SENSE_FALLING = 2'h2,
    SENSE_RISING = 2'h3
  } epiv_sense_type;

  // Request toward the core
  typedef struct packed
  {
    logic valid;
    logic [4:0] vector;
  } epiv_req_type;

  // Other sources in vector order 4..16
  typedef struct packed
  {
    logic serial_overflow_src;
    logic serial_start_src;
    logic eeprom_ready_src;
    logic converter_src;
    logic comparator_src;
    logic timer8_overflow_src;
    logic timer8_compare_b_src;
    logic timer8_compare_a_src;
    logic timer16_overflow_src;
    logic timer16_compare_b_src;
    logic timer16_compare_a_src;
    logic timer16_capture_src;
    logic watchdog_timeout_src;
  } epiv_src_type;

endpackage

// >>> verif/epiv_top_monitor.sv
module epiv_top_monitor
  import epiv_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic io_clk_en,
  input wire logic global_irq_enable,
  input wire logic ext_irq_pin,
  input wire epiv_src_type other_src,
  input wire logic hsel,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire epiv_req_type irq_req,
  input wire logic reset_vector_valid,
  input wire logic [4:0] reset_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Vectors and gating
  property p_reset_vec;
    reset_vector_valid && reset_vector == VEC_RESET;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector not zero");
  property p_global;
    irq_req.valid |-> $past(global_irq_enable);
  endproperty
  a_global: assert property (p_global) else $error("request without global enable");
  property p_watchdog;
    global_irq_enable && other_src.watchdog_timeout_src |=> irq_req.valid
      && irq_req.vector <= VEC_WATCHDOG;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog not served first");
  property p_serial;
    global_irq_enable && other_src == 13'h1000 |=> irq_req.vector <= VEC_SERIAL_OVERFLOW;
  endproperty
  a_serial: assert property (p_serial) else $error("serial overflow vector too high");
  property p_range;
    irq_req.valid |-> irq_req.vector inside {[VEC_EXT:VEC_SERIAL_OVERFLOW]};
  endproperty
  a_range: assert property (p_range) else $error("vector outside table");
  property p_hold;
    global_irq_enable && other_src != 13'h0000 |=> irq_req.valid;
  endproperty
  a_hold: assert property (p_hold) else $error("level source not requested");
  // Edges need the I/O clock; a stopped clock must not invent one
  property p_edge_gated;
    (!io_clk_en && ext_irq_pin && !hsel && !irq_req.valid && other_src == 13'h0000
      && global_irq_enable) [*3] |=> !irq_req.valid;
  endproperty
  a_edge_gated: assert property (p_edge_gated) else $error("edge seen without clock");
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or error");
  c_ext: cover property (irq_req.valid && irq_req.vector == VEC_EXT);
  c_low: cover property (irq_req.valid && irq_req.vector == VEC_PCH_LOW);
  c_high: cover property (irq_req.valid && irq_req.vector == VEC_PCH_HIGH);
endmodule
bind epiv_top epiv_top_monitor mon_u (.clk, .rstn, .io_clk_en, .global_irq_enable,
  .ext_irq_pin, .other_src, .hsel, .hreadyout, .hresp, .irq_req, .reset_vector_valid,
  .reset_vector);

// >>> verif/epiv_core_model.sv
module epiv_core_model
  import epiv_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire epiv_req_type irq_req,
  input wire logic hold_off,
  input wire logic slow,
  output logic irq_ack,
  output logic taken,
  output logic [4:0] taken_vec
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    irq_ack = 1'b0;
    taken = 1'b0;
    taken_vec = 5'h00;
  end
  // Cool-down after each ack, so a late drop of valid is never taken twice
  always
  begin
    @(posedge clk);
    if (rstn && irq_req.valid && !hold_off)
    begin
      if (slow)
        repeat (3) @(posedge clk);
      irq_ack <= 1'b1;
      taken <= 1'b1;
      taken_vec <= irq_req.vector;
      @(posedge clk);
      irq_ack <= 1'b0;
      taken <= 1'b0;
      repeat (2) @(posedge clk);
    end
  end
endmodule

// >>> verif/test_ext_pin_interrupt_vectoring.sv
module test_ext_pin_interrupt_vectoring
  import epiv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, io_clk_en = 1'b1, global_irq_enable = 1'b0;
  logic startup_done = 1'b1, ext_irq_pin = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic hold_off = 1'b0, slow = 1'b0, irq_ack, taken, hreadyout, hresp, wake_req;
  logic reset_vector_valid;
  logic [PIN_W-1:0] pins = 12'h000, grp;
  epiv_src_type other_src = 13'h0000;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] reset_vector, taken_vec;
  logic [4:0] exp_q[$];
  epiv_req_type irq_req;
  int n_mismatch = 0, check_count = 0, seed = 32'h5515;
  always #5 clk = ~clk;
  epiv_top dut_u (.clk, .rstn, .io_clk_en, .global_irq_enable, .irq_ack, .startup_done,
    .ext_irq_pin, .pin_change_inputs(pins), .other_src, .haddr, .htrans, .hwrite, .hsize,
    .hsel, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .irq_req, .wake_req,
    .reset_vector_valid, .reset_vector);
  epiv_core_model core_u (.clk, .rstn, .irq_req, .hold_off, .slow, .irq_ack, .taken,
    .taken_vec);
  // ==========================================================================
  // Checking and closing
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // A take with nothing noted gets 1F, which no source owns
  always @(posedge clk)
    if (taken === 1'b1)
      cmp("vector", 32'(exp_q.size() != 0 ? exp_q.pop_front() : 5'h1F), 32'(taken_vec));
  // ==========================================================================
  // Bus and wait helpers
  task automatic rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 100)
      begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp("hrdata", exp, hrdata);
  endtask
  task automatic drain();
    for (int i = 0; i < 40 && exp_q.size() != 0; i++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    cmp("pending", 32'h0, 32'(exp_q.size()));
  endtask
  // ==========================================================================
  // Scenarios
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_CORE_CONTROL, 32'h0);
    rd(ADDR_GENERAL_MASK, 32'h0);
    rd(ADDR_FLAGS, 32'h0);
    rd(8'h18, 32'h0);
    r = $random(seed);
    bus(1'b1, ADDR_MASK_LOW, r);
    rd(ADDR_MASK_LOW, r & 32'hFF);
    bus(1'b1, ADDR_MASK_HIGH, r);
    rd(ADDR_MASK_HIGH, r & 32'hF);
    hold_off <= 1'b1;
    global_irq_enable <= 1'b1;
    for (int i = 0; i < 13; i++)
    begin
      other_src <= epiv_src_type'(13'(1 << i));
      repeat (3) @(posedge clk);
      cmp("vector", 32'(VEC_WATCHDOG + i), 32'(irq_req.vector));
    end
    other_src <= epiv_src_type'(13'h1001);
    repeat (3) @(posedge clk);
    cmp("vector", 32'(VEC_WATCHDOG), 32'(irq_req.vector));
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("valid", 32'h0, 32'(irq_req.valid));
    other_src <= 13'h0000;
    global_irq_enable <= 1'b1;
    hold_off <= 1'b0;
    bus(1'b1, ADDR_GENERAL_MASK, 32'h30);
    for (int k = 0; k < PIN_W; k++)
    begin
      grp = k < 8 ? 12'h0FF : 12'hF00;
      slow <= k[0];
      bus(1'b1, k < 8 ? ADDR_MASK_LOW : ADDR_MASK_HIGH, 32'(1 << (k % 8)));
      pins <= pins ^ (grp & ~(12'(1) << k));
      drain();
      exp_q.push_back(k < 8 ? VEC_PCH_LOW : VEC_PCH_HIGH);
      pins <= pins ^ (12'(1) << k);
      drain();
    end
    rd(ADDR_FLAGS, 32'h0);
    hold_off <= 1'b1;
    pins <= pins ^ 12'h800;
    repeat (6) @(posedge clk);
    rd(ADDR_FLAGS, 32'h20);
    bus(1'b1, ADDR_FLAGS, 32'h20);
    rd(ADDR_FLAGS, 32'h0);
    hold_off <= 1'b0;
    io_clk_en <= 1'b0;
    pins <= pins ^ 12'h800;
    @(posedge clk);
    cmp("wake", 32'h1, 32'(wake_req));
    pins <= pins ^ 12'h800;
    repeat (2) @(posedge clk);
    io_clk_en <= 1'b1;
    bus(1'b1, ADDR_GENERAL_MASK, 32'h40);
    for (int s = 1; s < 4; s++)
    begin
      bus(1'b1, ADDR_CORE_CONTROL, 32'(s));
      if (s != 3)
        exp_q.push_back(VEC_EXT);
      ext_irq_pin <= 1'b0;
      drain();
      if (s != 2)
        exp_q.push_back(VEC_EXT);
      ext_irq_pin <= 1'b1;
      drain();
    end
    io_clk_en <= 1'b0;
    ext_irq_pin <= 1'b0;
    repeat (4) @(posedge clk);
    ext_irq_pin <= 1'b1;
    repeat (5) @(posedge clk);
    io_clk_en <= 1'b1;
    drain();
    hold_off <= 1'b1;
    bus(1'b1, ADDR_CORE_CONTROL, 32'h0);
    ext_irq_pin <= 1'b0;
    repeat (8) @(posedge clk);
    cmp("request", 32'({1'b1, VEC_EXT}), 32'(irq_req));
    rd(ADDR_FLAGS, 32'h0);
    startup_done <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("valid", 32'h0, 32'(irq_req.valid));
    cmp("wake", 32'h1, 32'(wake_req));
    ext_irq_pin <= 1'b1;
    repeat (3) @(posedge clk);
    startup_done <= 1'b1;
    hold_off <= 1'b0;
    drain();
    end_of_test();
  end
endmodule
